/* include/spm_pkg.sv */
package spm_pkg;

    localparam int SPM_BITS = 8;
    localparam logic [4:0] SPM_LAST_EDGE = 5'h0f;
    localparam int SPM_BUF_DEPTH = 2;

    // sck half periods in clk_sys cycles, indexed by {rate_select_hi, rate_select_lo}
    localparam logic [6:0] SPM_HALF_DIV4 = 7'h02;
    localparam logic [6:0] SPM_HALF_DIV16 = 7'h08;
    localparam logic [6:0] SPM_HALF_DIV64 = 7'h20;
    localparam logic [6:0] SPM_HALF_DIV128 = 7'h40;

    localparam logic [7:0] SPM_DATA_RESET = 8'h00;

    typedef struct packed {
        logic xfer_irq_enable;
        logic port_enable;
        logic bit_order_select;
        logic master_select;
        logic clk_polarity;
        logic clk_phase;
        logic rate_select_hi;
        logic rate_select_lo;
        logic double_rate;
    } spm_ctrl_t;

    localparam spm_ctrl_t SPM_CTRL_RESET = '0;

    // user direction bits, 1 = output
    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss;
    } spm_dir_t;

    typedef struct packed {
        logic xfer_done_flag;
        logic write_collision_flag;
    } spm_status_t;

endpackage : spm_pkg

/* rtl/spm_buf2.sv */
`timescale 1ns/1ps
module spm_buf2
    import spm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [SPM_BITS-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [SPM_BITS-1:0] out_data
);
    logic [SPM_BITS-1:0] tail;
    logic tail_full;

    // head register drives the outputs straight from flops; tail catches a word while the head stalls
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire head_free = pop | ~out_valid;

    assign in_ready = ~tail_full;

    always_ff @(posedge clk_sys)
    begin
        if (head_free)
        begin
            out_data <= tail_full ? tail : in_data;
        end
        if (push && !head_free)
        begin
            tail <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            tail_full <= 1'b0;
        end
        else if (head_free)
        begin
            out_valid <= tail_full | push;
            tail_full <= 1'b0;
        end
        else if (push)
        begin
            tail_full <= 1'b1;
        end
    end

endmodule : spm_buf2

/* rtl/spm_port.sv */
// Overview of operation
// - master data write shifts eight bits out
// - master stops clock, sets done, may interrupt
// - master never drives select automatically
// - software drives select low by gpio, high after each packet
// - mosi master-to-slave, miso slave-to-master, simultaneously
// - slave deselected: miso released, sck ignored
// - deselected slave accepts data writes for next transfer
// - slave byte complete sets done, may interrupt
// - each received byte held until next completes
// - single transmit buffer, separate receive buffer
// - enabled port overrides pin directions per mode
// - slave selected drives miso only if configured
// - slave deselect resets counter, drops partial byte
// - master output select is plain gpio
// - master input select low falls back to slave
// - fallback sets done, interrupt needs both enables
// - order bit: set lsb first, clear msb first
// - polarity sets idle level, phase sets sample edge
// - rate bits and double rate divide sck
// - collision flag; status read then data clears
`timescale 1ns/1ps
module spm_port
    import spm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire spm_ctrl_t ctrl_wdata,
    output spm_ctrl_t ctrl_rdata,
    input wire spm_dir_t pin_dir,
    input wire logic ss_gpio_value,
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire logic stat_rd,
    output spm_status_t stat_rdata,
    input wire logic data_wr,
    input wire logic [SPM_BITS-1:0] data_wdata,
    input wire logic data_rd,
    output logic [SPM_BITS-1:0] data_rdata,
    output logic irq,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [SPM_BITS-1:0] rx_data,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic ss_in,
    output logic ss_out,
    output logic ss_oe
);
    spm_ctrl_t ctrl;
    logic ss_s1;
    logic ss_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic mi_s1;
    logic mi_s2;
    logic mo_s1;
    logic mo_s2;
    logic [SPM_BITS-1:0] shift_data_reg;
    logic [SPM_BITS-1:0] rx_hold;
    logic out_bit;
    logic [4:0] edge_cnt;
    logic m_busy;
    logic m_pend;
    logic [6:0] div_cnt;
    logic [2:0] m_samp_d;
    logic [2:0] m_end_d;
    logic [SPM_BITS-1:0] m_rx_sr;
    logic sck_q;
    logic done_q;
    logic write_collision_flag_q;
    logic clr_arm;
    logic buf_ready;
    logic buf_valid;
    logic [SPM_BITS-1:0] buf_data;

    // two-flop synchronisers on every pin that enters the clk_sys domain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_prev <= 1'b0;
            mi_s1 <= 1'b0;
            mi_s2 <= 1'b0;
            mo_s1 <= 1'b0;
            mo_s2 <= 1'b0;
        end
        else
        begin
            ss_s1 <= ss_in;
            ss_s2 <= ss_s1;
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_prev <= sck_s2;
            mi_s1 <= miso_in;
            mi_s2 <= mi_s1;
            mo_s1 <= mosi_in;
            mo_s2 <= mo_s1;
        end
    end

    wire is_master_select = ctrl.port_enable & ctrl.master_select;
    wire is_slv = ctrl.port_enable & ~ctrl.master_select;
    wire slv_sel = is_slv & ~ss_s2;
    // select as input pulled low while master: another master owns the bus
    wire mode_fault = is_master_select & ~pin_dir.ss & ~ss_s2;

    wire [1:0] rate = {ctrl.rate_select_hi, ctrl.rate_select_lo};
    wire [6:0] half_norm = (rate == 2'h0) ? SPM_HALF_DIV4 :
                           (rate == 2'h1) ? SPM_HALF_DIV16 :
                           (rate == 2'h2) ? SPM_HALF_DIV64 : SPM_HALF_DIV128;
    wire [6:0] half = ctrl.double_rate ? (half_norm >> 1) : half_norm;
    wire tick = m_busy & (div_cnt == half - 7'h01);

    // external sck is only seen through the synchroniser, hence the quarter-rate limit
    wire s_edge = slv_sel & (sck_s2 != sck_prev);
    wire any_edge = is_master_select ? tick : s_edge;
    wire lead = is_master_select ? (sck_q == ctrl.clk_polarity) : (sck_s2 != ctrl.clk_polarity);
    wire samp_edge = any_edge & (lead ^ ctrl.clk_phase);
    wire setup_edge = any_edge & ~(lead ^ ctrl.clk_phase);
    wire last_edge = any_edge & (edge_cnt == SPM_LAST_EDGE);

    wire rx_bit = is_master_select ? mi_s2 : mo_s2;
    wire first_bit = ctrl.bit_order_select ? shift_data_reg[0] : shift_data_reg[SPM_BITS-1];
    wire [SPM_BITS-1:0] sr_shift = ctrl.bit_order_select ?
        {rx_bit, shift_data_reg[SPM_BITS-1:1]} :
        {shift_data_reg[SPM_BITS-2:0], rx_bit};
    // master miso returns through the synchroniser three cycles after our sck edge, so capture waits as long
    wire m_samp = m_samp_d[2];
    wire m_fin = m_end_d[2];
    wire [SPM_BITS-1:0] m_rx_shift = ctrl.bit_order_select ?
        {mi_s2, m_rx_sr[SPM_BITS-1:1]} :
        {m_rx_sr[SPM_BITS-2:0], mi_s2};
    wire [SPM_BITS-1:0] m_rx_byte = m_samp ? m_rx_shift : m_rx_sr;
    wire [SPM_BITS-1:0] rx_byte = is_master_select ? m_rx_byte : (samp_edge ? sr_shift : shift_data_reg);
    wire byte_end = is_master_select ? m_fin : last_edge;

    wire shifting = m_busy | m_pend | (m_end_d != 3'h0) | (slv_sel & (edge_cnt != 5'h00));
    wire wr_ok = data_wr & ~shifting;
    wire wr_coll = data_wr & shifting;
    wire m_start = m_pend & buf_ready & ~mode_fault;
    wire done_set = byte_end | mode_fault;
    wire flag_clr = clr_arm & (data_rd | data_wr);

    wire next_mosi_oe = is_master_select ? pin_dir.mosi : (is_slv ? 1'b0 : pin_dir.mosi);
    wire next_sck_oe = is_master_select ? pin_dir.sck : (is_slv ? 1'b0 : pin_dir.sck);
    wire next_ss_oe = is_master_select ? pin_dir.ss : (is_slv ? 1'b0 : pin_dir.ss);
    wire next_miso_oe = is_master_select ? 1'b0 : (is_slv ? (pin_dir.miso & ~ss_s2) : pin_dir.miso);

    // control register; hardware clear on mode fault beats a same-cycle write
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl <= SPM_CTRL_RESET;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ctrl <= ctrl_wdata;
            end
            if (mode_fault)
            begin
                ctrl.master_select <= 1'b0;
            end
        end
    end

    // master start and sck generation
    always_ff @(posedge clk_sys)
    begin
        if (rst || !is_master_select || mode_fault)
        begin
            m_pend <= 1'b0;
            m_busy <= 1'b0;
            div_cnt <= 7'h00;
            sck_q <= ctrl.clk_polarity;
            m_samp_d <= 3'h0;
            m_end_d <= 3'h0;
            m_rx_sr <= SPM_DATA_RESET;
        end
        else
        begin
            m_samp_d <= {m_samp_d[1:0], samp_edge};
            m_end_d <= {m_end_d[1:0], last_edge};
            m_rx_sr <= m_rx_byte;
            if (wr_ok)
            begin
                m_pend <= 1'b1;
            end
            else if (m_start)
            begin
                m_pend <= 1'b0;
            end
            if (m_start)
            begin
                m_busy <= 1'b1;
                div_cnt <= 7'h00;
            end
            else if (last_edge)
            begin
                m_busy <= 1'b0;
                div_cnt <= 7'h00;
            end
            else if (tick)
            begin
                div_cnt <= 7'h00;
            end
            else if (m_busy)
            begin
                div_cnt <= div_cnt + 7'h01;
            end
            if (tick)
            begin
                sck_q <= ~sck_q;
            end
            else if (!m_busy)
            begin
                sck_q <= ctrl.clk_polarity;
            end
        end
    end

    // shared shift engine for both modes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shift_data_reg <= SPM_DATA_RESET;
            edge_cnt <= 5'h00;
            out_bit <= 1'b0;
        end
        else
        begin
            if (wr_ok)
            begin
                shift_data_reg <= data_wdata;
            end
            else if (samp_edge)
            begin
                shift_data_reg <= sr_shift;
            end
            if ((is_slv && ss_s2) || !ctrl.port_enable || mode_fault || last_edge)
            begin
                edge_cnt <= 5'h00;
            end
            else if (any_edge)
            begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            if (setup_edge || (!m_busy && !any_edge && !(slv_sel && edge_cnt != 5'h00)) || (is_slv && ss_s2))
            begin
                out_bit <= first_bit;
            end
        end
    end

    // receive hold register and status flags
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_hold <= SPM_DATA_RESET;
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            clr_arm <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            if (byte_end)
            begin
                rx_hold <= rx_byte;
            end
            if (done_set)
            begin
                done_q <= 1'b1;
            end
            else if (flag_clr || irq_ack)
            begin
                done_q <= 1'b0;
            end
            if (wr_coll)
            begin
                write_collision_flag_q <= 1'b1;
            end
            else if (flag_clr)
            begin
                write_collision_flag_q <= 1'b0;
            end
            if (stat_rd)
            begin
                clr_arm <= done_q | write_collision_flag_q;
            end
            else if (data_rd || data_wr)
            begin
                clr_arm <= 1'b0;
            end
            irq <= (done_q | done_set) & ~irq_ack & ctrl.xfer_irq_enable & global_irq_enable;
        end
    end

    // registered pin drivers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
            sck_out <= 1'b0;
            ss_out <= 1'b1;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            sck_oe <= 1'b0;
            ss_oe <= 1'b0;
        end
        else
        begin
            mosi_out <= out_bit;
            miso_out <= out_bit;
            sck_out <= sck_q;
            ss_out <= ss_gpio_value;
            mosi_oe <= next_mosi_oe;
            miso_oe <= next_miso_oe;
            sck_oe <= next_sck_oe;
            ss_oe <= next_ss_oe;
        end
    end

    assign ctrl_rdata = ctrl;
    assign stat_rdata = '{xfer_done_flag: done_q, write_collision_flag: write_collision_flag_q};
    assign data_rdata = rx_hold;

    // received bytes also stream out; a full buffer holds off the next master start
    spm_buf2 u_rx_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(byte_end),
        .in_ready(buf_ready),
        .in_data(rx_byte),
        .out_valid(buf_valid),
        .out_ready(rx_ready),
        .out_data(buf_data)
    );

    assign rx_valid = buf_valid;
    assign rx_data = buf_data;

endmodule : spm_port

/* testbench/spm_port_chk.sv */
`timescale 1ns/1ps
module spm_port_chk
    import spm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire spm_ctrl_t ctrl_rdata,
    input wire spm_dir_t pin_dir,
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire spm_status_t stat_rdata,
    input wire logic [SPM_BITS-1:0] data_rdata,
    input wire logic irq,
    input wire logic rx_valid,
    input wire logic [SPM_BITS-1:0] rx_data,
    input wire logic ss_in,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic sck_oe,
    input wire logic ss_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire logic on_m = ctrl_rdata.port_enable && ctrl_rdata.master_select;
    wire logic on_s = ctrl_rdata.port_enable && !ctrl_rdata.master_select;
    // pin enables are registered behind control and direction, so wait until both settle
    sequence s_settled;
        ($stable(ctrl_rdata) && $stable(pin_dir))[*2];
    endsequence
    sequence s_deselected;
        (on_s && ss_in)[*5];
    endsequence
    a_ss_plain_gpio: assert property (s_settled ##0 (on_m && pin_dir.ss) |-> ss_oe)
        else $error("select pin not a gpio");
    a_master_miso_in: assert property (s_settled ##0 on_m |-> !miso_oe)
        else $error("master drives miso");
    a_slave_all_in: assert property (s_settled ##0 on_s |-> !(mosi_oe || sck_oe || ss_oe))
        else $error("slave drives an input pin");
    a_miso_released: assert property (s_deselected |-> !miso_oe)
        else $error("deselected slave drives miso");
    a_fault_sets_done: assert property ($fell(ctrl_rdata.master_select) && !$past(ctrl_wr)
        |-> ##[0:1] stat_rdata.xfer_done_flag)
        else $error("fallback without done");
    a_ack_drops_irq: assert property (irq_ack |-> ##[1:2] !irq)
        else $error("irq kept after ack");
    a_irq_needs_enables: assert property (irq |-> $past(global_irq_enable) && $past(ctrl_rdata.xfer_irq_enable))
        else $error("irq without enables");
    a_rx_hold_match: assert property ($rose(rx_valid) |-> ##[0:1] rx_data == data_rdata)
        else $error("stream and hold differ");
endmodule : spm_port_chk

bind spm_port spm_port_chk u_chk (.clk_sys, .rst, .ctrl_wr, .ctrl_rdata, .pin_dir, .global_irq_enable,
    .irq_ack, .stat_rdata, .data_rdata, .irq, .rx_valid, .rx_data, .ss_in, .mosi_oe, .miso_oe, .sck_oe, .ss_oe);

/* testbench/spm_slave_model.sv */
`timescale 1ns/1ps
module spm_slave_model
    import spm_pkg::*;
(
    input wire logic en,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic [SPM_BITS-1:0] tx_byte,
    output logic miso,
    output logic [SPM_BITS-1:0] rx_byte
);
    logic [SPM_BITS-1:0] sh = '0;
    initial miso = 1'b0;
    initial rx_byte = '0;
    // mode 0, msb first: first bit is set up as soon as select falls
    always @(negedge ss_n)
        if (en)
        begin
            sh = tx_byte;
            miso = sh[7];
        end
    always @(posedge sck)
        if (en && !ss_n) rx_byte = {rx_byte[6:0], mosi};
    always @(negedge sck)
        if (en && !ss_n)
        begin
            sh = sh << 1;
            miso = sh[7];
        end
    // no pull on miso: a released line shows the opposite of its last bit
    always @(posedge ss_n) miso = ~miso;
endmodule : spm_slave_model

/* testbench/spi_master_slave_port_tb.sv */
`timescale 1ns/1ps
module spi_master_slave_port_tb;
    import spm_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, irq_ack = 1'b0, stat_rd = 1'b0;
    logic data_wr = 1'b0, data_rd = 1'b0, rx_ready = 1'b0, gpio = 1'b1, gie = 1'b1;
    logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1, m_en = 1'b1;
    logic [SPM_BITS-1:0] wdata = '0, m_tx = '0, m_rx, rdata, rx_data, got;
    spm_ctrl_t ctrl = '0, c, ctrl_rdata;
    spm_dir_t dir = '0;
    spm_status_t stat;
    logic irq, rx_valid, mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, ss_out, ss_oe, m_miso;
    logic [7:0] hc = '0, half_seen = '0;
    logic [6:0] halves [4] = '{SPM_HALF_DIV4, SPM_HALF_DIV16, SPM_HALF_DIV64, SPM_HALF_DIV128};
    int mismatches = 0, n_compared = 0;
    wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire logic miso_w = miso_oe ? miso_out : m_miso;
    wire logic sck_w = sck_oe ? sck_out : tb_sck;
    wire logic ss_w = ss_oe ? ss_out : tb_ss;

    spm_port dut (.clk_sys, .rst, .ctrl_wr, .ctrl_wdata(ctrl), .ctrl_rdata, .pin_dir(dir), .ss_gpio_value(gpio),
        .global_irq_enable(gie), .irq_ack, .stat_rd, .stat_rdata(stat), .data_wr, .data_wdata(wdata), .data_rd,
        .data_rdata(rdata), .irq, .rx_valid, .rx_ready, .rx_data, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
        .miso_in(miso_w), .miso_out, .miso_oe, .sck_in(sck_w), .sck_out, .sck_oe, .ss_in(ss_w), .ss_out, .ss_oe);
    spm_slave_model u_slv (.en(m_en), .sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .tx_byte(m_tx), .miso(m_miso),
        .rx_byte(m_rx));

    always #20 clk_sys = ~clk_sys;
    // width of the last high phase of the master clock
    always @(posedge clk_sys)
        if (sck_out) hc <= hc + 8'h01;
        else if (hc != 8'h00)
        begin
            half_seen <= hc;
            hc <= 8'h00;
        end

    function automatic logic [7:0] rev(logic [7:0] v);
        for (int k = 0; k < 8; k++) rev[k] = v[7-k];
    endfunction : rev
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    task automatic set_ctrl(spm_ctrl_t v);
        ctrl = v;
        pulse(ctrl_wr);
        tick(2);
    endtask : set_ctrl
    task automatic clear_flags;
        pulse(stat_rd);
        pulse(data_rd);
        chk(stat, 2'b00);
    endtask : clear_flags
    task automatic wait_done;
        int i;
        for (i = 0; i < 4000 && stat.xfer_done_flag !== 1'b1; i++) tick(1);
        if (i == 4000)
        begin
            mismatches++;
            wrap_up();
        end
    endtask : wait_done
    task automatic pop(logic [7:0] e);
        chk(rx_valid, 1'b1);
        chk(rx_data, e);
        pulse(rx_ready);
    endtask : pop
    task automatic mxfer(logic [7:0] d, logic [7:0] t, logic p);
        m_tx = t;
        gpio = 1'b0;
        tick(4);
        wdata = d;
        pulse(data_wr);
        wait_done();
        chk(ss_out, 1'b0);
        chk(m_rx, ctrl.bit_order_select ? rev(d) : d);
        chk(rdata, ctrl.bit_order_select ? rev(t) : t);
        if (p) pop(ctrl.bit_order_select ? rev(t) : t);
        gpio = 1'b1;
        tick(4);
    endtask : mxfer
    // external master, mode 0, msb first, well below a quarter of clk_sys
    task automatic ext(int n, logic [7:0] o);
        got = '0;
        for (int k = 0; k < n; k++)
        begin
            tb_mosi = o[7];
            o = o << 1;
            tick(6);
            got = {got[6:0], miso_w};
            tb_sck = 1'b1;
            tick(4);
            tb_sck = 1'b0;
        end
        tick(6);
    endtask : ext

    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(2);
        chk({ctrl_rdata, stat, ss_out}, 12'h001);
        dir = 4'b1011;
        for (int i = 0; i < 8; i++)
        begin
            c = '0;
            c.port_enable = 1'b1;
            c.master_select = 1'b1;
            c.xfer_irq_enable = 1'b1;
            c.bit_order_select = i[0];
            {c.rate_select_hi, c.rate_select_lo, c.double_rate} = i[2:0];
            set_ctrl(c);
            mxfer(8'ha3 + 8'(i), 8'h96 - 8'(i), 1'b1);
            chk(irq, 1'b1);
            chk(half_seen, halves[i[2:1]] >> i[0]);
            if (i == 7) pulse(irq_ack);
            if (i == 7) chk(irq, 1'b0);
            clear_flags();
        end
        c.bit_order_select = 1'b0;
        {c.rate_select_hi, c.rate_select_lo, c.double_rate} = 3'h0;
        set_ctrl(c);
        mxfer(8'h01, 8'h10, 1'b0);
        clear_flags();
        mxfer(8'h02, 8'h20, 1'b0);
        clear_flags();
        m_tx = 8'h30;
        gpio = 1'b0;
        tick(4);
        wdata = 8'h03;
        pulse(data_wr);
        tick(300);
        chk(stat.xfer_done_flag, 1'b0);
        pop(8'h10);
        pop(8'h20);
        wait_done();
        pop(8'h30);
        chk(m_rx, 8'h03);
        gpio = 1'b1;
        tick(4);
        clear_flags();
        m_tx = 8'h44;
        gpio = 1'b0;
        tick(4);
        wdata = 8'h55;
        pulse(data_wr);
        wdata = 8'h66;
        pulse(data_wr);
        chk(stat.write_collision_flag, 1'b1);
        wait_done();
        chk(m_rx, 8'h55);
        pop(8'h44);
        gpio = 1'b1;
        tick(4);
        clear_flags();
        dir = 4'b1010;
        gie = 1'b0;
        tick(2);
        tb_ss = 1'b0;
        tick(6);
        chk(ctrl_rdata.master_select, 1'b0);
        chk(stat.xfer_done_flag, 1'b1);
        chk({sck_oe, mosi_oe, irq}, 3'h0);
        gie = 1'b1;
        tick(2);
        chk(irq, 1'b1);
        tb_ss = 1'b1;
        clear_flags();
        dir = 4'b1011;
        set_ctrl(c);
        chk(ctrl_rdata.master_select, 1'b1);
        c.clk_polarity = 1'b1;
        set_ctrl(c);
        chk(sck_out, 1'b1);
        m_en = 1'b0;
        dir = 4'b0100;
        c = '0;
        c.port_enable = 1'b1;
        set_ctrl(c);
        wdata = 8'hc3;
        pulse(data_wr);
        ext(3, 8'hff);
        chk(miso_oe, 1'b0);
        tb_ss = 1'b0;
        tick(6);
        chk(miso_oe, 1'b1);
        ext(8, 8'h81);
        chk(got, 8'hc3);
        chk(rdata, 8'h81);
        chk(stat.xfer_done_flag, 1'b1);
        pop(8'h81);
        clear_flags();
        ext(3, 8'hff);
        tb_ss = 1'b1;
        tick(6);
        tb_ss = 1'b0;
        tick(6);
        ext(8, 8'h5a);
        chk(rdata, 8'h5a);
        pop(8'h5a);
        tb_ss = 1'b1;
        tick(4);
        wrap_up();
    end
endmodule : spi_master_slave_port_tb
